// file: bench/acs_sar_model.sv
// comparator model of the analog mux and converter
// assumes trial_code is stepped as a sar by the block
`timescale 1ns/1ps
module acs_sar_model (
  input wire logic pclk,
  input wire logic [4:0] channel_select,
  input wire logic [7:0] trial_code,
  input wire logic converter_power_down,
  input wire logic [7:0] bias,
  output logic cmp_high
);
  logic tog = 1'b0;
  // ==========
  // level per channel, noise while powered off
  always @(posedge pclk)
  begin
    tog <= !tog;
  end
  assign cmp_high = converter_power_down ? tog :
    ({channel_select, 3'h5} + bias >= trial_code);
endmodule : acs_sar_model

// file: bench/acs_top_asserts.sv
// port checker of the converter control block
// assumes the acs_top ports and the package register map
`timescale 1ns/1ps
module acs_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [4:0] channel_select,
  input wire logic sample_hold,
  input wire logic converter_power_down,
  input wire logic done_irq
);
  logic acc, wst, rres;
  assign acc = psel && penable && pready;
  assign wst = acc && pwrite && paddr == acs_pkg::OFS_STATUS_CONTROL;
  assign rres = acc && !pwrite && paddr == acs_pkg::OFS_RESULT;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========
  // properties
  property p_pd;
    converter_power_down == (channel_select == 5'h1f);
  endproperty
  a_pd: assert property (p_pd) else $error("pd");
  property p_pdh;
    converter_power_down |-> !sample_hold;
  endproperty
  a_pdh: assert property (p_pdh) else $error("pd hold");
  property p_ch;
    wst |=> channel_select == $past(pwdata[4:0]);
  endproperty
  a_ch: assert property (p_ch) else $error("chan");
  property p_go;
    wst && pwdata[4:0] != 5'h1f |=> sample_hold;
  endproperty
  a_go: assert property (p_go) else $error("start");
  property p_wc;
    wst |=> !done_irq;
  endproperty
  a_wc: assert property (p_wc) else $error("irq wr");
  property p_rc;
    rres |=> !done_irq || $rose(done_irq) || $rose(sample_hold);
  endproperty
  a_rc: assert property (p_rc) else $error("irq rd");
  property p_len;
    $fell(sample_hold) |-> !$rose(done_irq) [*8];
  endproperty
  a_len: assert property (p_len) else $error("len");
  property p_rst;
    $rose(presetn) |-> converter_power_down && !done_irq;
  endproperty
  a_rst: assert property (p_rst) else $error("rst");
  c_irq: cover property ($rose(done_irq));
  c_pd: cover property ($rose(converter_power_down));
  c_go: cover property (wst ##1 sample_hold);
endmodule : acs_chk
bind acs_top acs_chk u_acs_chk (.*);

// file: bench/adc_control_status_clock_tb.sv
// self-checking bench of the converter control block
// assumes acs_top, its checker and the comparator model
`timescale 1ns/1ps
module adc_control_status_clock_tb;
  localparam logic [11:0] ST = acs_pkg::OFS_STATUS_CONTROL;
  localparam logic [11:0] RS = acs_pkg::OFS_RESULT;
  localparam logic [11:0] CK = acs_pkg::OFS_CLOCK_SELECT;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, xtal_tick = 1'b0, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [7:0] bias = 8'h00, trial_code;
  logic [4:0] channel_select;
  logic pready, pslverr, cmp_high, sample_hold, converter_power_down;
  logic done_irq;
  int miscompares = 0, total_checks = 0, cyc = 0, n[7];
  logic [4:0] chs[6] = '{5'h00, 5'h07, 5'h08, 5'h0e, 5'h1d, 5'h1e};
  logic [7:0] cks[7] = '{8'h10, 8'h70, 8'h90, 8'hf0, 8'h00, 8'h30,
                         8'h50};
  always #2 pclk = !pclk;
  acs_top u_acs_top (.*);
  acs_sar_model u_acs_sar_model (.*);
  // ==========
  // tasks
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wait_done(output int k);
    k = 0;
    do
    begin
      apb(1'b0, ST, 8'h00);
      k++;
    end while (r[7] !== 1'b1 && k < 4000);
    chk("done", 32'(r[7]), 32'h1);
  endtask : wait_done
  function automatic logic [31:0] expv(input logic [4:0] c);
    if (c == acs_pkg::CH_REF_HIGH)
      return 32'hff;
    if (c == acs_pkg::CH_REF_LOW)
      return 32'h00;
    return 32'({c, 3'h5} + bias);
  endfunction : expv
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    xtal_tick <= cyc % 4 == 0;
    if (cyc == 20000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  // ==========
  // tests
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ST, 8'h00);
    chk("st_rst", r, 32'h1f);
    apb(1'b0, CK, 8'h00);
    chk("ck_rst", r, 32'h00);
    apb(1'b0, 12'h00c, 8'h00);
    chk("unmapped", 32'(e), 32'h1);
    apb(1'b1, CK, 8'h10);
    apb(1'b0, CK, 8'h00);
    chk("ck_rw", r, 32'h10);
    $display("test registers done");
    foreach (chs[i])
    begin
      apb(1'b1, ST, {3'h0, chs[i]});
      wait_done(n[5]);
      apb(1'b0, RS, 8'h00);
      chk("result", r, expv(chs[i]));
      apb(1'b0, ST, 8'h00);
      chk("flag_clr", r, {27'h0, chs[i]});
    end
    repeat (100) @(posedge pclk);
    apb(1'b0, ST, 8'h00);
    chk("single", 32'(r[7]), 32'h0);
    $display("test channels done");
    foreach (cks[i])
    begin
      apb(1'b1, CK, cks[i]);
      apb(1'b1, ST, 8'h03);
      wait_done(n[i]);
      apb(1'b0, RS, 8'h00);
      chk("div_res", r, expv(5'h03));
    end
    chk("div8", 32'(n[1] > 4 * n[0]), 32'h1);
    chk("div16", 32'(n[2] > n[1] + n[1] / 2), 32'h1);
    chk("div16x", 32'(n[2] < n[3] + 3 && n[3] < n[2] + 3), 32'h1);
    chk("xtal", 32'(n[4] > n[0]), 32'h1);
    chk("div2", 32'(n[5] > n[0]), 32'h1);
    chk("div4", 32'(n[6] > n[5] && n[1] > n[6]), 32'h1);
    $display("test clocks done");
    apb(1'b1, CK, 8'h10);
    apb(1'b1, ST, 8'h43);
    wait_done(n[5]);
    chk("irq_set", 32'(done_irq), 32'h1);
    apb(1'b0, RS, 8'h00);
    chk("irq_clr", 32'(done_irq), 32'h0);
    $display("test interrupt done");
    apb(1'b1, ST, 8'h25);
    wait_done(n[5]);
    apb(1'b0, RS, 8'h00);
    chk("cont_1", r, expv(5'h05));
    bias <= 8'h11;
    repeat (100) @(posedge pclk);
    apb(1'b0, ST, 8'h00);
    chk("cont_flag", r, 32'h25);
    apb(1'b1, CK, 8'h90);
    apb(1'b0, CK, 8'h00);
    chk("ck_busy", r, 32'h10);
    apb(1'b0, RS, 8'h00);
    chk("cont_2", r, expv(5'h05));
    apb(1'b1, ST, 8'h1f);
    chk("pwr_off", 32'(converter_power_down), 32'h1);
    $display("test continuous done");
    tally_and_finish();
  end
endmodule : adc_control_status_clock_tb

// file: hdl/acs_prescaler.sv
// converter clock prescaler: source select and power-of-two divider
// assumes xtal_tick is a one-cycle pulse synchronous to pclk
`timescale 1ns/1ps
module acs_prescaler (
  input wire logic pclk,
  input wire logic presetn,
  acs_clk_if.presc ck
);
  // ==========================================================
  // divide ratio decode
  function automatic logic [3:0] div_mask(input logic [2:0] sel);
    logic [3:0] m;
    m = 4'h0;
    if (sel[2])
    begin
      m = 4'hf; // [R12]
    end
    else
    begin
      case (sel[1:0])
        2'd0: m = 4'h0;
        2'd1: m = 4'h1;
        2'd2: m = 4'h3;
        default: m = 4'h7;
      endcase
    end
    return m;
  endfunction : div_mask

  logic [acs_pkg::DIV_CNT_W-1:0] cnt_q;
  logic [acs_pkg::DIV_CNT_W-1:0] cnt_d;
  logic tick_q;
  logic tick_d;
  logic src_tick;

  // ==========================================================
  // divider
  always_comb
  begin
    src_tick = ck.src_bus ? 1'b1 : ck.xtal_tick; // [R14]
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (!ck.run)
    begin
      cnt_d = '0;
    end
    else if (src_tick)
    begin
      if (cnt_q >= div_mask(ck.div_sel))
      begin
        cnt_d = '0;
        tick_d = 1'b1; // [R12]
      end
      else
      begin
        cnt_d = cnt_q + 4'd1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign ck.adc_tick = tick_q;
endmodule : acs_prescaler

// file: hdl/acs_top.sv
// converter control block: apb registers, sequencing, channel select
// assumes an external sar converter that answers each compare step
`timescale 1ns/1ps
module acs_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic xtal_tick,
  input wire logic cmp_high,
  output logic [4:0] channel_select,
  output logic [7:0] trial_code,
  output logic sample_hold,
  output logic converter_power_down,
  output logic done_irq
);
  acs_clk_if ck ();

  acs_prescaler u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .ck(ck)
  );

  // ==========================================================
  // decode helpers
  function automatic logic [2:0] reg_sel(input logic [11:0] a);
    logic [2:0] s;
    s = 3'b000;
    if (a == acs_pkg::OFS_STATUS_CONTROL)
    begin
      s = 3'b001;
    end
    else if (a == acs_pkg::OFS_RESULT)
    begin
      s = 3'b010;
    end
    else if (a == acs_pkg::OFS_CLOCK_SELECT)
    begin
      s = 3'b100;
    end
    return s;
  endfunction : reg_sel

  function automatic logic is_power_off(input logic [4:0] c);
    return c == acs_pkg::CH_POWER_OFF;
  endfunction : is_power_off

  function automatic logic [7:0] trial_bit(input logic [2:0] pos);
    return 8'h80 >> pos;
  endfunction : trial_bit

  function automatic logic [7:0] forced_code(input logic [4:0] c,
                                              input logic [7:0] code);
    logic [7:0] v;
    v = code;
    if (c == acs_pkg::CH_REF_HIGH)
    begin
      v = acs_pkg::RESULT_FULL; // [R20] [R8]
    end
    else if (c == acs_pkg::CH_REF_LOW)
    begin
      v = acs_pkg::RESULT_ZERO; // [R20] [R8]
    end
    return v;
  endfunction : forced_code

  // ==========================================================
  // bus decode
  logic acc;
  logic wr_sc;
  logic wr_clk;
  logic rd_res;
  logic hit;
  logic [2:0] sel;

  always_comb
  begin
    acc = psel && penable;
    sel = reg_sel(paddr);
    wr_sc = 1'b0;
    wr_clk = 1'b0;
    rd_res = 1'b0;
    hit = 1'b1;
    if (sel[0])
    begin
      wr_sc = acc && pwrite;
    end
    else if (sel[1])
    begin
      rd_res = acc && !pwrite;
    end
    else if (sel[2])
    begin
      wr_clk = acc && pwrite;
    end
    else
    begin
      hit = 1'b0;
    end
  end

  assign pready = 1'b1;
  assign pslverr = acc && !hit;

  // ==========================================================
  // registers and sequencer state
  logic done_q, done_d;
  logic irq_q, irq_d;
  logic irq_en_q, irq_en_d;
  logic rep_q, rep_d;
  logic [4:0] ch_q, ch_d;
  logic [7:0] clk_q, clk_d;
  logic [7:0] res_q, res_d;
  logic [7:0] sar_q, sar_d;
  logic [4:0] step_q, step_d;
  logic first_q, first_d;
  acs_pkg::acs_state_t st_q, st_d;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic finish;
  logic [7:0] final_code;

  assign ck.src_bus = clk_q[acs_pkg::BIT_SRC];
  assign ck.div_sel = clk_q[acs_pkg::DIV_LSB +: acs_pkg::DIV_W];
  assign ck.xtal_tick = xtal_tick;
  assign ck.run = (st_q != acs_pkg::ACS_IDLE);

  // ==========================================================
  // conversion sequencer
  always_comb
  begin
    st_d = st_q;
    sar_d = sar_q;
    step_d = step_q;
    finish = 1'b0;
    case (st_q)
      acs_pkg::ACS_IDLE:
      begin
        st_d = acs_pkg::ACS_IDLE;
      end
      acs_pkg::ACS_SYNC:
      begin
        // first converter edge aligns the run: 16 or 17 clocks total
        if (ck.adc_tick)
        begin
          st_d = acs_pkg::ACS_CONVERT; // [R18]
          sar_d = 8'h80;
          step_d = 5'd1;
        end
      end
      default:
      begin
        if (ck.adc_tick)
        begin
          step_d = step_q + 5'd1;
          if (step_q[0])
          begin
            // odd step samples comparator, even step sets next trial
            sar_d = cmp_high ? sar_q : (sar_q & ~trial_bit(step_q[3:1]));
          end
          else
          begin
            sar_d = sar_q | trial_bit(step_q[3:1]);
          end
          if (step_q == acs_pkg::CONV_CLOCKS - 5'd1)
          begin
            finish = 1'b1; // [R18]
            step_d = '0;
            st_d = rep_q ? acs_pkg::ACS_SYNC : acs_pkg::ACS_IDLE; // [R4]
          end
        end
      end
    endcase
    final_code = forced_code(ch_q, sar_d);
    if (wr_sc)
    begin
      st_d = is_power_off(pwdata[4:0]) ?
             acs_pkg::ACS_IDLE : acs_pkg::ACS_SYNC; // [R17] [R9]
      step_d = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sar_q <= 8'h00;
      step_q <= '0;
      st_q <= acs_pkg::ACS_IDLE;
    end
    else
    begin
      sar_q <= sar_d;
      step_q <= step_d;
      st_q <= st_d;
    end
  end

  // ==========================================================
  // register updates
  always_comb
  begin
    done_d = done_q;
    irq_d = irq_q;
    irq_en_d = irq_en_q;
    rep_d = rep_q;
    ch_d = ch_q;
    clk_d = clk_q;
    res_d = res_q;
    first_d = first_q;
    if (wr_sc || rd_res)
    begin
      done_d = 1'b0; // [R2]
      irq_d = 1'b0; // [R3]
    end
    if (wr_sc)
    begin
      irq_en_d = pwdata[acs_pkg::BIT_IRQ_EN];
      rep_d = pwdata[acs_pkg::BIT_REPEAT];
      ch_d = pwdata[acs_pkg::CH_LSB +: acs_pkg::CH_W]; // [R6] [R7]
      first_d = 1'b1;
    end
    if (wr_clk && st_q == acs_pkg::ACS_IDLE)
    begin
      clk_d = pwdata[7:0]; // [R16]
    end
    if (finish && !wr_sc)
    begin
      res_d = final_code; // [R11] [R19]
      first_d = 1'b0;
      if (!irq_en_q && (first_q || !rep_q))
      begin
        done_d = 1'b1; // [R1]
      end
      if (irq_en_q)
      begin
        irq_d = 1'b1; // [R3]
      end
    end
  end

  // ==========================================================
  // readback mux
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (sel[0])
    begin
      rdata_d[7:0] = {done_q | irq_q, irq_en_q, rep_q, ch_q};
    end
    else if (sel[1])
    begin
      rdata_d[7:0] = res_q;
    end
    else if (sel[2])
    begin
      rdata_d[7:0] = {clk_q[7:4], 4'h0};
    end
  end

  // ==========================================================
  // register bank
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_q <= 1'b0; // [R5]
      irq_q <= 1'b0;
      irq_en_q <= 1'b0; // [R5]
      rep_q <= 1'b0; // [R5]
      ch_q <= acs_pkg::RST_STATUS_CONTROL[4:0];
      clk_q <= acs_pkg::RST_CLOCK_SELECT; // [R14]
      res_q <= acs_pkg::RST_RESULT;
      first_q <= 1'b0;
    end
    else
    begin
      done_q <= done_d;
      irq_q <= irq_d;
      irq_en_q <= irq_en_d;
      rep_q <= rep_d;
      ch_q <= ch_d;
      clk_q <= clk_d;
      res_q <= res_d;
      first_q <= first_d;
    end
  end

  // ==========================================================
  // outputs
  assign rdata_q = rdata_d;
  assign prdata = rdata_q;
  assign channel_select = ch_q; // [R6] [R8]
  assign trial_code = sar_q;
  assign sample_hold = (st_q == acs_pkg::ACS_SYNC);
  assign converter_power_down = is_power_off(ch_q); // [R9]
  assign done_irq = irq_q; // [R3]
endmodule : acs_top

// file: shared/acs_clk_if.sv
// carries the converter clock tick between prescaler and controller
// assumes both ends run on pclk
`timescale 1ns/1ps
interface acs_clk_if;
  logic src_bus;
  logic [2:0] div_sel;
  logic xtal_tick;
  logic run;
  logic adc_tick;
  modport ctrl (output src_bus, output div_sel, output xtal_tick,
                output run, input adc_tick);
  modport presc (input src_bus, input div_sel, input xtal_tick,
                 input run, output adc_tick);
endinterface : acs_clk_if

// file: shared/acs_pkg.sv
// constants, field layouts and types of the converter control block
// assumes an apb master with 32-bit data and one word per register
// Function
// (R1) done flag set per conversion; continuous: first only
// (R2) write control or read result clears flag
// (R3) irq at each end, dropped on read/write
// (R4) continuous mode repeats; otherwise exactly one conversion
// (R5) reset clears flag, irq enable, repeat bit
// (R6) channel codes pick port b and port d
// (R7) codes 0f-1a, 1c unused; 1b reserved
// (R8) codes 1d/1e select high/low reference node
// (R9) all-ones channel powers converter off
// (R10) software waits one conversion after power-up
// (R11) eight-bit result loaded at each completion
// (R12) divider field: 1,2,4,8, top bit sixteen
// (R13) software targets about one megahertz converter clock
// (R14) source bit: one bus clock, zero crystal
// (R15) slow crystal: software picks bus clock
// (R16) clock settings unchanged during a conversion
// (R17) control write starts a new conversion
// (R18) conversion takes 16 to 17 converter clocks
// (R19) continuous result overwrites unread result
// (R20) high reference gives ff, low gives 00
package acs_pkg;
  // ==========================================================
  // register map
  localparam logic [11:0] OFS_STATUS_CONTROL = 12'h000;
  localparam logic [11:0] OFS_RESULT = 12'h004;
  localparam logic [11:0] OFS_CLOCK_SELECT = 12'h008;
  // ==========================================================
  // status/control fields
  localparam int BIT_DONE = 7;
  localparam int BIT_IRQ_EN = 6;
  localparam int BIT_REPEAT = 5;
  localparam int CH_LSB = 0;
  localparam int CH_W = 5;
  // ==========================================================
  // clock select fields
  localparam int DIV_LSB = 5;
  localparam int DIV_W = 3;
  localparam int BIT_SRC = 4;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_STATUS_CONTROL = 8'h1f;
  localparam logic [7:0] RST_CLOCK_SELECT = 8'h00;
  localparam logic [7:0] RST_RESULT = 8'h00;
  // ==========================================================
  // channel codes
  localparam logic [4:0] CH_PORTD_LAST = 5'h0e;
  localparam logic [4:0] CH_RESERVED = 5'h1b;
  localparam logic [4:0] CH_REF_HIGH = 5'h1d;
  localparam logic [4:0] CH_REF_LOW = 5'h1e;
  localparam logic [4:0] CH_POWER_OFF = 5'h1f;
  localparam logic [7:0] RESULT_FULL = 8'hff;
  localparam logic [7:0] RESULT_ZERO = 8'h00;
  // ==========================================================
  // timing: successive approximation steps per conversion
  localparam logic [4:0] CONV_CLOCKS = 5'd16;
  localparam int DIV_CNT_W = 4;

  typedef enum logic [1:0] {
    ACS_IDLE,
    ACS_SYNC,
    ACS_CONVERT
  } acs_state_t;
endpackage : acs_pkg
